/* File: src/dltm_pkg.sv */
package dltm_pkg;
  // register map
  localparam logic [7:0] REG_LED_MON = 8'h06;
  localparam logic [7:0] REG_DROOP = 8'h07;
  localparam logic [7:0] REG_VALLEY = 8'h08;
  // led monitor register fields
  localparam int LED_TS_EN_BIT = 7;
  localparam int LED_HOT_BIT = 6;
  localparam int LED_WARN_BIT = 5;
  // droop control register fields
  localparam int DRP_EN_BIT = 7;
  localparam int DRP_THR_LSB = 4;
  localparam int DRP_SPARE_BIT = 3;
  localparam int DRP_REV_LSB = 0;
  // valley limit register field
  localparam int VAL_SEL_BIT = 0;
  // reset values
  localparam logic DRP_EN_RST = 1'h0;
  localparam logic [2:0] DRP_THR_RST = 3'h4;
  localparam logic DRP_SPARE_RST = 1'h0;
  localparam logic TS_EN_RST = 1'h0;
  localparam logic VAL_SEL_RST = 1'h0;
  // fixed silicon revision, value arbitrary
  localparam logic [2:0] SILICON_REV = 3'h1;
  // droop threshold code meaning: 50 mV plus 25 mV per code step
  localparam int DROOP_BASE_MV = 50;
  localparam int DROOP_STEP_MV = 25;
  // valley limit select meaning: 0 gives 1250 mA, 1 gives 1750 mA
  localparam int VALLEY_LOW_MA = 1250;
  localparam int VALLEY_HIGH_MA = 1750;
  // i2c framing
  localparam logic [3:0] I2C_ACK_SLOT = 4'h8;
  localparam logic [3:0] I2C_LAST_BIT = 4'h7;
  // synchroniser idle levels, bit 0 scl, bit 1 sda, bit 2 warn, bit 3 hot
  localparam logic [3:0] SYNC_IDLE = 4'h3;

  // host-written control bits
  typedef struct packed {
    logic droop_en;
    logic [2:0] droop_thr;
    logic spare;
    logic ts_en;
    logic valley_sel;
  } dltm_ctrl_t;

  // hardware-set temperature flags
  typedef struct packed {
    logic warn;
    logic hot;
  } dltm_flags_t;
endpackage : dltm_pkg

/* File: src/dltm_regs.sv */
`timescale 1ns/1ps
// Summary of operation
// RULE1: droop control bit 7 switches battery droop monitoring on or off.
// RULE2: droop bits 6..4 pick threshold, 50mV plus 25mV per code step.
// RULE3: host selects valley current limit 1250mA or 1750mA over serial link.
// RULE4: thermistor bias source is on exactly while temperature monitoring is enabled.
// RULE5: warning flag set whenever comparator reports input below warning threshold; code sets it only while led monitor bit 7 is one.
// RULE6: host read of led monitor register clears the warning flag.
// RULE7: below hot threshold sets overtemp flag and forces shutdown at once; code does so only while led monitor bit 7 is one.
// RULE8: overtemp flag and shutdown stay latched until host clears; reads never release.
// RULE9: writing zero clears overtemp flag; writing one leaves it unchanged.
// RULE10: warning trips below 1.05V, overtemp below 0.345V, via external comparators.
// RULE11: led monitor bit 7 enables temperature monitoring, reset value zero.
// RULE12: revision bits 2..0 read a fixed value and ignore writes.
// RULE13: droop spare bit 3 stores host data, resets to zero, no effect.
module dltm_regs #(
  parameter logic [6:0] P_I2C_ADDR = 7'h33
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // i2c link, sda open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // thermistor comparators, high while below threshold
  input wire logic i_ts_below_warn,
  input wire logic i_ts_below_hot,
  // analog controls
  output logic o_droop_monitor_enable,
  output logic [2:0] o_droop_threshold_sel,
  output logic o_valley_limit_select,
  output logic o_ts_bias_enable,
  output logic o_shutdown
);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA} dltm_state_t;

  // input synchronisers: raw, second, third stage plus filtered value
  logic [3:0] raw_in;
  logic [2:0] sync_q [4];
  logic [2:0] sync_d [4];
  logic [3:0] filt_q;
  logic [3:0] filt_d;
  logic scl_f;
  logic sda_f;
  logic warn_f;
  logic hot_f;

  assign raw_in = {i_ts_below_hot, i_ts_below_warn, i_sda, i_scl};
  assign scl_f = filt_q[0];
  assign sda_f = filt_q[1];
  assign warn_f = filt_q[2]; // RULE10
  assign hot_f = filt_q[3]; // RULE10

  // three flops per pin; a change counts only once stages two and three agree
  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_comb begin
      sync_d[g] = {sync_q[g][1:0], raw_in[g]};
      filt_d[g] = (sync_q[g][1] == sync_q[g][2]) ? sync_q[g][1] : filt_q[g];
    end
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        // start at the pin's idle level so release gives no false edge
        sync_q[g] <= {3{dltm_pkg::SYNC_IDLE[g]}};
        filt_q[g] <= dltm_pkg::SYNC_IDLE[g];
      end else begin
        sync_q[g] <= sync_d[g];
        filt_q[g] <= filt_d[g];
      end
    end
  end

  // bus events from the filtered levels
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  assign scl_rise = ~scl_f & filt_d[0];
  assign scl_fall = scl_f & ~filt_d[0];
  assign i2c_start = scl_f & filt_d[0] & sda_f & ~filt_d[1];
  assign i2c_stop = scl_f & filt_d[0] & ~sda_f & filt_d[1];

  // protocol and register state
  dltm_state_t state_q, state_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] tx_q, tx_d;
  logic oe_q, oe_d;
  dltm_pkg::dltm_ctrl_t ctrl_q, ctrl_d;
  dltm_pkg::dltm_flags_t flags_q, flags_d;
  logic wr_stb;
  logic ld_stb;
  logic rd_clear;
  logic hot_clear;

  // read view of the map; unmapped offsets and unused bits read zero
  function automatic logic [7:0] rd_byte(input logic [7:0] ptr,
                                         input dltm_pkg::dltm_ctrl_t c,
                                         input dltm_pkg::dltm_flags_t f);
    logic [7:0] v;
    v = 8'h00;
    unique case (ptr)
      dltm_pkg::REG_LED_MON: begin
        v[dltm_pkg::LED_TS_EN_BIT] = c.ts_en;
        v[dltm_pkg::LED_HOT_BIT] = f.hot;
        v[dltm_pkg::LED_WARN_BIT] = f.warn;
      end
      dltm_pkg::REG_DROOP: begin
        v[dltm_pkg::DRP_EN_BIT] = c.droop_en;
        v[dltm_pkg::DRP_THR_LSB +: 3] = c.droop_thr;
        v[dltm_pkg::DRP_SPARE_BIT] = c.spare;
        v[dltm_pkg::DRP_REV_LSB +: 3] = dltm_pkg::SILICON_REV; // RULE12
      end
      dltm_pkg::REG_VALLEY: v[dltm_pkg::VAL_SEL_BIT] = c.valley_sel;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_byte

  // byte framing: data bits sampled on scl rise, sda changed after scl fall
  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    tx_d = tx_q;
    oe_d = oe_q;
    wr_stb = 1'b0;
    ld_stb = 1'b0;
    if (i2c_start) begin
      state_d = ST_ADDR;
      bit_cnt_d = dltm_pkg::I2C_ACK_SLOT; // scl fall after start wraps this to bit 0
      oe_d = 1'b0;
    end else if (i2c_stop) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (state_q != ST_IDLE) begin
      if (scl_rise) begin
        if (bit_cnt_q != dltm_pkg::I2C_ACK_SLOT) begin
          shift_d = {shift_q[6:0], sda_f};
        end else if (state_q == ST_RDATA) begin
          if (sda_f) begin
            state_d = ST_IDLE; // master nack ends the read
          end else begin
            ld_stb = 1'b1; // our address ack or a master ack: fetch the next byte
          end
        end
      end
      if (scl_fall) begin
        bit_cnt_d = (bit_cnt_q == dltm_pkg::I2C_ACK_SLOT) ? 4'h0 : bit_cnt_q + 4'h1;
        if (bit_cnt_q == dltm_pkg::I2C_LAST_BIT) begin
          oe_d = 1'b1;
          unique case (state_q)
            ST_ADDR: begin
              if (shift_q[7:1] != P_I2C_ADDR) begin
                state_d = ST_IDLE;
                oe_d = 1'b0;
              end else if (shift_q[0]) begin
                state_d = ST_RDATA; // byte is fetched at the ack rise, once
              end else begin
                state_d = ST_PTR;
              end
            end
            ST_PTR: begin
              ptr_d = shift_q;
              state_d = ST_WDATA;
            end
            ST_WDATA: wr_stb = 1'b1;
            default: oe_d = 1'b0; // read: release for master ack
          endcase
        end else if (state_q == ST_RDATA) begin
          oe_d = ~tx_q[7]; // open drain: drive only zeros
          tx_d = {tx_q[6:0], 1'b0};
        end else begin
          oe_d = 1'b0;
        end
      end
    end
    if (ld_stb) begin
      tx_d = rd_byte(ptr_q, ctrl_q, flags_q);
    end
    if (ld_stb || wr_stb) begin
      ptr_d = ptr_q + 8'h01; // auto increment for burst access
    end
  end

  // register writes and hardware flags; a set always beats a clear
  always_comb begin
    ctrl_d = ctrl_q;
    hot_clear = 1'b0;
    rd_clear = ld_stb && (ptr_q == dltm_pkg::REG_LED_MON); // RULE6
    if (wr_stb) begin
      unique case (ptr_q)
        dltm_pkg::REG_LED_MON: begin
          ctrl_d.ts_en = shift_q[dltm_pkg::LED_TS_EN_BIT]; // RULE11
          hot_clear = ~shift_q[dltm_pkg::LED_HOT_BIT]; // RULE9
        end
        dltm_pkg::REG_DROOP: begin
          ctrl_d.droop_en = shift_q[dltm_pkg::DRP_EN_BIT]; // RULE1
          ctrl_d.droop_thr = shift_q[dltm_pkg::DRP_THR_LSB +: 3]; // RULE2
          ctrl_d.spare = shift_q[dltm_pkg::DRP_SPARE_BIT]; // RULE13
        end
        dltm_pkg::REG_VALLEY: ctrl_d.valley_sel = shift_q[dltm_pkg::VAL_SEL_BIT]; // RULE3
        default: ctrl_d = ctrl_q;
      endcase
    end
    flags_d.warn = (flags_q.warn & ~rd_clear) | (ctrl_q.ts_en & warn_f); // RULE5
    // only an explicit zero write releases the latch, reads do not
    flags_d.hot = (flags_q.hot & ~hot_clear) | (ctrl_q.ts_en & hot_f); // RULE7 RULE8
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      tx_q <= 8'h00;
      oe_q <= 1'b0;
      ctrl_q <= '{droop_en: dltm_pkg::DRP_EN_RST, droop_thr: dltm_pkg::DRP_THR_RST,
                  spare: dltm_pkg::DRP_SPARE_RST, ts_en: dltm_pkg::TS_EN_RST,
                  valley_sel: dltm_pkg::VAL_SEL_RST};
      flags_q <= '{warn: 1'b0, hot: 1'b0};
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      tx_q <= tx_d;
      oe_q <= oe_d;
      ctrl_q <= ctrl_d;
      flags_q <= flags_d;
    end
  end

  // outputs straight from flops, except o_sda_out which is tied to zero
  assign o_sda_out = 1'b0;
  assign o_sda_oe = oe_q;
  assign o_droop_monitor_enable = ctrl_q.droop_en;
  assign o_droop_threshold_sel = ctrl_q.droop_thr;
  assign o_valley_limit_select = ctrl_q.valley_sel;
  assign o_ts_bias_enable = ctrl_q.ts_en; // RULE4
  assign o_shutdown = flags_q.hot; // RULE7

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_wr(logic [7:0] a);
    wr_stb && (ptr_q == a);
  endsequence
  sequence s_hot_trip;
    ctrl_q.ts_en && hot_f;
  endsequence

  AST_DROOP_EN: assert property (s_wr(dltm_pkg::REG_DROOP) |=> // RULE1
    o_droop_monitor_enable == $past(shift_q[7])) else $error("droop enable not written");
  AST_DROOP_THR: assert property (s_wr(dltm_pkg::REG_DROOP) |=> // RULE2
    o_droop_threshold_sel == $past(shift_q[6:4])) else $error("droop threshold not written");
  AST_VALLEY: assert property (s_wr(dltm_pkg::REG_VALLEY) |=> // RULE3
    o_valley_limit_select == $past(shift_q[0])) else $error("valley select not written");
  AST_TS_BIAS: assert property (s_wr(dltm_pkg::REG_LED_MON) |=> // RULE4
    o_ts_bias_enable == $past(shift_q[7])) else $error("bias not following enable");
  AST_WARN_SET: assert property (ctrl_q.ts_en && warn_f |=> flags_q.warn) // RULE5
    else $error("warning flag not set");
  AST_WARN_RDCLR: assert property (rd_clear && !(ctrl_q.ts_en && warn_f) |=> // RULE6
    !flags_q.warn) else $error("warning not cleared by read");
  AST_HOT_SHDN: assert property (s_hot_trip |=> o_shutdown [*2]) // RULE7
    else $error("overtemp did not force shutdown");
  AST_HOT_HOLD: assert property (o_shutdown && !hot_clear |=> o_shutdown) // RULE8
    else $error("shutdown released without clear");
  AST_HOT_W1: assert property (s_wr(dltm_pkg::REG_LED_MON) && shift_q[6] && o_shutdown |=> // RULE9
    o_shutdown) else $error("write one changed overtemp flag");
  AST_REV: assert property (ld_stb && ptr_q == dltm_pkg::REG_DROOP |=> // RULE12
    tx_q[2:0] == dltm_pkg::SILICON_REV) else $error("revision field wrong");
  AST_SPARE: assert property (s_wr(dltm_pkg::REG_DROOP) ##1 !wr_stb |-> // RULE13
    ctrl_q.spare == $past(shift_q[3], 1)) else $error("spare bit not stored");
endmodule : dltm_regs

/* File: tb/dltm_host.sv */
`timescale 1ns/1ps
// i2c host model; the bus has a pull-up
module dltm_host (
  // clock and bus
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl = 1'b1,
  output logic o_sda = 1'b1,
  // finished read byte
  output logic [7:0] o_rd_data = 8'h00,
  output logic o_rd_vld = 1'b0
);
  int unsigned gap = 0; // extra wait per phase, makes a slow host
  task automatic w(input int n);
    repeat (n + gap) @(posedge i_ref_clk);
  endtask : w
  // phases stay well over the filter minimum; late change covers the ack release
  task automatic pulse(output logic v);
    w(4);
    o_scl <= 1'b1;
    w(7);
    @(negedge i_ref_clk) v = i_sda;
    @(posedge i_ref_clk) o_scl <= 1'b0;
    w(10);
  endtask : pulse
  task automatic start();
    o_sda <= 1'b1;
    w(4);
    o_scl <= 1'b1;
    w(8);
    o_sda <= 1'b0; // falls under high scl
    w(8);
    o_scl <= 1'b0;
    w(8);
  endtask : start
  task automatic stop();
    o_sda <= 1'b0;
    w(4);
    o_scl <= 1'b1;
    w(8);
    o_sda <= 1'b1; // rises under high scl
    w(8);
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      o_sda <= d[i];
      pulse(v);
    end
    o_sda <= 1'b1; // released so the device can ack
    pulse(v);
    ack = ~v;
  endtask : wbyte
  // nack high ends a read
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic v;
    o_sda <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pulse(v);
      d[i] = v;
    end
    o_sda <= nack;
    pulse(v);
    o_rd_data <= d;
    o_rd_vld <= 1'b1;
    @(posedge i_ref_clk) o_rd_vld <= 1'b0;
  endtask : rbyte
endmodule : dltm_host

/* File: tb/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module tb;
  localparam logic [6:0] dev_adr = 7'h33;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic warn = 1'b0;
  logic hot = 1'b0;
  logic scl, hsda, sda, so, soe, den, val, bias, sdn, vld, ack, ok;
  logic [2:0] thr;
  logic [7:0] rdat, d, ev;
  logic [7:0] eq[$];
  int bad_count = 0;
  int num_checks = 0;
  // open-drain wire with pull-up
  assign sda = hsda & ~(soe & ~so);
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  dltm_regs #(.P_I2C_ADDR(dev_adr)) uut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_scl(scl), .i_sda(sda), .o_sda_out(so), .o_sda_oe(soe), .i_ts_below_warn(warn),
    .i_ts_below_hot(hot), .o_droop_monitor_enable(den), .o_droop_threshold_sel(thr),
    .o_valley_limit_select(val), .o_ts_bias_enable(bias), .o_shutdown(sdn));
  dltm_host host (.i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl), .o_sda(hsda),
    .o_rd_data(rdat), .o_rd_vld(vld));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // address and pointer phase, acks gathered in ok
  task automatic head(input logic [7:0] p);
    host.start();
    host.wbyte({dev_adr, 1'b0}, ack);
    ok = ack;
    host.wbyte(p, ack);
    ok &= ack;
  endtask : head
  task automatic wr(input logic [7:0] p, b0, b1, input logic two);
    head(p);
    host.wbyte(b0, ack);
    ok &= ack;
    if (two) host.wbyte(b1, ack);
    host.stop();
    `CHK(ok & ack, 1'b1)
  endtask : wr
  // notes the expected byte, then reads it
  task automatic rd(input logic [7:0] p, e);
    logic [7:0] r;
    eq.push_back(e);
    head(p);
    host.start();
    host.wbyte({dev_adr, 1'b1}, ack);
    host.rbyte(1'b1, r);
    host.stop();
    `CHK(ok & ack, 1'b1)
  endtask : rd
  // comparator levels, then time for the input filter
  task automatic ts(input logic w, h);
    warn <= w;
    hot <= h;
    repeat (8) @(posedge i_ref_clk);
  endtask : ts
  // each finished read against the oldest note
  always @(posedge i_ref_clk) begin
    if (vld === 1'b1) begin
      ev = (eq.size() > 0) ? eq.pop_front() : 8'hXX;
      `CHK(rdat, ev)
    end
  end
  initial begin
    void'($urandom(32'hA954));
    repeat (2) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    `CHK({den, thr, val, bias, sdn, soe}, 8'h40)
    rd(8'h07, {5'h08, dltm_pkg::SILICON_REV});
    rd(8'h06, 8'h00);
    // every threshold code; burst runs on into the valley register
    for (int c = 0; c < 8; c++) begin
      d = 8'($urandom);
      d[6:4] = 3'(c);
      d[0] = c[0];
      host.gap = $urandom_range(2);
      wr(8'h07, d, {7'h00, d[0]}, 1'b1);
      `CHK({den, thr, val}, {d[7:4], d[0]})
      rd(8'h07, {d[7:3], dltm_pkg::SILICON_REV});
    end
    host.gap = 0;
    wr(8'h06, 8'h80, 8'h00, 1'b0);
    `CHK(bias, 1'b1)
    ts(1'b1, 1'b0);
    ts(1'b0, 1'b0);
    rd(8'h06, 8'hA0);
    rd(8'h06, 8'h80);
    ts(1'b1, 1'b1);
    `CHK(sdn, 1'b1)
    ts(1'b0, 1'b0);
    rd(8'h06, 8'hE0);
    rd(8'h06, 8'hC0);
    wr(8'h06, 8'hC0, 8'h00, 1'b0);
    `CHK(sdn, 1'b1)
    wr(8'h06, 8'h80, 8'h00, 1'b0);
    `CHK(sdn, 1'b0)
    rd(8'h06, 8'h80);
    wr(8'h06, 8'h00, 8'h00, 1'b0);
    ts(1'b1, 1'b1);
    `CHK({bias, sdn}, 2'b00)
    ts(1'b0, 1'b0);
    rd(8'h06, 8'h00);
    rd(8'h20, 8'h00);
    // foreign address must not be acked
    host.start();
    host.wbyte({dev_adr ^ 7'h01, 1'b0}, ack);
    host.stop();
    `CHK(ack, 1'b0)
    repeat (4) @(posedge i_ref_clk);
    `CHK(eq.size(), 0)
    print_verdict();
  end
  // traffic needs about 26k cycles
  initial begin
    repeat (90000) @(posedge i_ref_clk);
    bad_count++;
    print_verdict();
  end
endmodule : tb
